// ===== rtl/tboc_pkg.sv
// tboc_pkg: constants, types and decode functions of the tape buffer option loader
package tboc_pkg;

   // ---------------------------------------------------------------
   // switch positions, bit index is switch number minus one
   // ---------------------------------------------------------------
   localparam int SWA_RATE_0 = 0;
   localparam int SWA_RATE_1 = 1;
   localparam int SWA_RAMP_DELAY_LO = 2;
   localparam int SWA_RAMP_DELAY_HI = 3;
   localparam int SWA_BLOCK_LIMIT_LO = 4;
   localparam int SWA_BLOCK_LIMIT_HI = 5;
   localparam int SWA_RATE_2 = 6;
   localparam int SWA_SINGLE_TRACK_WRITE_FIX = 7;
   localparam int SWA_CACHE_LO = 8;
   localparam int SWA_CACHE_HI = 9;
   localparam int SWB_WRITE_RETRY_LO = 0;
   localparam int SWB_WRITE_RETRY_HI = 1;
   localparam int SWB_READ_RETRY_LO = 2;
   localparam int SWB_READ_RETRY_HI = 3;
   localparam int SWB_TM_SYNC = 4;
   localparam int SWB_EARLY_EOT = 5;
   localparam int SWB_LONG_RECORD = 7;
   localparam int SWB_FMT_ADDR = 8;
   localparam int SW_COUNT = 10;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLOCK_PERIOD_NS = 10;
   localparam int RAMP_UNIT_NS = 1000000;
   localparam int RAMP_UNIT_CYCLES = RAMP_UNIT_NS / CLOCK_PERIOD_NS;
   localparam int RAMP_CNT_W = 21;
   localparam logic [1:0] BOOT_SETTLE = 2'h2;

   // ---------------------------------------------------------------
   // widths and limits
   // ---------------------------------------------------------------
   localparam int RATE_W = 10;
   localparam int BLK_W = 16;
   localparam logic [15:0] BLK_UNIT_BYTES = 16'h2000;
   localparam int REC_W = 4;
   localparam logic [3:0] EOT_REC_LIMIT = 4'h4;
   localparam logic [3:0] SINGLE_REC_LIMIT = 4'h1;
   localparam logic [1:0] TM_PAIR = 2'h2;
   localparam logic [1:0] TM_ONE = 2'h1;

   typedef struct packed {
      logic [2:0] rate_code;
      logic [1:0] ramp_code;
      logic [1:0] block_code;
      logic single_track_write_fix;
      logic [1:0] cache_addr;
      logic [1:0] write_retry;
      logic [1:0] read_retry;
      logic tm_sync;
      logic early_eot_single;
      logic long_record;
      logic fmt_addr;
   } tboc_cfg_s;

   typedef enum logic [2:0] {
      RAMP_IDLE = 3'b001,
      RAMP_WAIT = 3'b010,
      RAMP_OPEN = 3'b100
   } tboc_ramp_e;

   // ---------------------------------------------------------------
   // decode functions
   // ---------------------------------------------------------------
   function automatic logic [9:0] rate_of(input logic [2:0] code);
      logic [9:0] r;
      r = 10'h000;
      unique case (code)
         3'h0: r = 10'h3e8;
         3'h1: r = 10'h341;
         3'h2: r = 10'h2ca;
         3'h3: r = 10'h271;
         3'h4: r = 10'h1f4;
         3'h5: r = 10'h139;
         3'h6: r = 10'h0c8;
         3'h7: r = 10'h04c;
      endcase
      return r;
   endfunction

   function automatic logic [3:0] retry_limit(input logic [1:0] code);
      logic [3:0] r;
      r = 4'h0;
      unique case (code)
         2'h0: r = 4'h0;
         2'h1: r = 4'h5;
         2'h2: r = 4'ha;
         2'h3: r = 4'hf;
      endcase
      return r;
   endfunction

   function automatic logic [3:0] ramp_min_ms(input logic [1:0] code);
      logic [3:0] r;
      r = 4'h1;
      unique case (code)
         2'h0: r = 4'h1;
         2'h1: r = 4'h4;
         2'h2: r = 4'h8;
         2'h3: r = 4'hc;
      endcase
      return r;
   endfunction

   function automatic logic [15:0] block_bytes(input logic [1:0] code);
      return 16'(BLK_UNIT_BYTES * ({14'h0000, code} + 16'h0001));
   endfunction

endpackage

// ===== rtl/tboc_ramp_timer.sv
// tboc_ramp_timer: interface ramp delay from busy falling to first strobe
`timescale 1ns/10ps
module tboc_ramp_timer #(
   parameter int P_CNT_W = 21
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_clk_en,
   // control
   input wire logic i_busy,
   input wire logic [P_CNT_W-1:0] i_delay,
   // status
   output logic o_ramp_ok
);

   tboc_pkg::tboc_ramp_e state;
   tboc_pkg::tboc_ramp_e next_state;
   logic busy_q;
   logic [P_CNT_W-1:0] count;
   wire busy_fell = busy_q & ~i_busy;
   wire delay_done = (count + P_CNT_W'(1)) >= i_delay;

   always_comb begin
      next_state = state;
      unique case (state)
         tboc_pkg::RAMP_IDLE: if (busy_fell) next_state = tboc_pkg::RAMP_WAIT;
         tboc_pkg::RAMP_WAIT: begin
            if (i_busy) next_state = tboc_pkg::RAMP_IDLE;
            else if (delay_done) next_state = tboc_pkg::RAMP_OPEN;
         end
         tboc_pkg::RAMP_OPEN: if (i_busy) next_state = tboc_pkg::RAMP_IDLE;
         default: next_state = tboc_pkg::RAMP_IDLE;
      endcase
   end

   // strobes wait the selected ramp after busy drops
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= tboc_pkg::RAMP_IDLE;
         busy_q <= 1'b0;
         count <= '0;
         o_ramp_ok <= 1'b0;
      end else if (i_clk_en) begin
         state <= next_state;
         busy_q <= i_busy;
         count <= (state == tboc_pkg::RAMP_WAIT) ? count + P_CNT_W'(1) : '0;
         o_ramp_ok <= (next_state == tboc_pkg::RAMP_OPEN);
      end
   end

   a_ramp_closed_busy: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      i_clk_en && busy_fell && i_delay > P_CNT_W'(1) |=> !o_ramp_ok)
      else $error("strobe allowed before ramp delay");

endmodule

// ===== rtl/tboc_top.sv
// tboc_top: option switch loader and buffer policy logic of the tape cache card
`timescale 1ns/10ps
module tboc_top #(
   parameter int P_MS_CYCLES = tboc_pkg::RAMP_UNIT_CYCLES,
   parameter int P_FREE_W = 17
) (
   // clock, reset, enable
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_clk_en,
   // switch pins and front panel
   input wire logic [tboc_pkg::SW_COUNT-1:0] i_bank_a,
   input wire logic [tboc_pkg::SW_COUNT-1:0] i_bank_b,
   input wire logic i_alt_interface,
   input wire logic i_panel_reset,
   // host interface timing
   input wire logic i_busy,
   input wire logic i_read_req,
   input wire logic i_write_req,
   // buffer state
   input wire logic [P_FREE_W-1:0] i_free_space,
   input wire logic [tboc_pkg::REC_W-1:0] i_rec_count,
   input wire logic i_early_eot,
   input wire logic i_actual_eot,
   // tape marks and records
   input wire logic i_tape_mark,
   input wire logic i_data_record,
   // error reports
   input wire logic i_wr_error,
   input wire logic i_one_track,
   input wire logic i_wr_done,
   input wire logic i_rd_error,
   input wire logic i_rd_done,
   // mode change
   input wire logic i_mode_wr,
   input wire logic i_mode_long,
   // decoded configuration
   output tboc_pkg::tboc_cfg_s o_cfg,
   output logic [tboc_pkg::RATE_W-1:0] o_rate_kbps,
   output logic o_rate_valid,
   output logic [tboc_pkg::BLK_W-1:0] o_block_limit,
   output logic [1:0] o_cache_addr,
   output logic o_fmt_addr,
   output logic o_long_record,
   // host strobes
   output logic o_host_read_strobe,
   output logic o_host_write_strobe,
   // buffer policy
   output logic o_read_ahead,
   output logic o_status_hold,
   output logic o_accept_write,
   output logic o_drain,
   output logic o_dummy_status_ok,
   output logic o_verify_first,
   output logic o_buffer_sync,
   // retry decisions
   output logic o_wr_retry,
   output logic o_wr_give_up,
   output logic o_rd_retry,
   output logic o_rd_give_up
);

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [tboc_pkg::SW_COUNT-1:0] bank_a_m;
   logic [tboc_pkg::SW_COUNT-1:0] bank_a_s;
   logic [tboc_pkg::SW_COUNT-1:0] bank_b_m;
   logic [tboc_pkg::SW_COUNT-1:0] bank_b_s;
   logic alt_m;
   logic alt_s;
   logic panel_m;
   logic panel_s;
   logic panel_q;

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bank_a_m <= '0;
         bank_a_s <= '0;
         bank_b_m <= '0;
         bank_b_s <= '0;
         alt_m <= 1'b0;
         alt_s <= 1'b0;
         panel_m <= 1'b0;
         panel_s <= 1'b0;
         panel_q <= 1'b0;
      end else if (i_clk_en) begin
         bank_a_m <= i_bank_a;
         bank_a_s <= bank_a_m;
         bank_b_m <= i_bank_b;
         bank_b_s <= bank_b_m;
         alt_m <= i_alt_interface;
         alt_s <= alt_m;
         panel_m <= i_panel_reset;
         panel_s <= panel_m;
         panel_q <= panel_s;
      end
   end

   // ---------------------------------------------------------------
   // load strobe after reset release or panel reset
   // ---------------------------------------------------------------
   logic [1:0] settle;
   wire boot_load = (settle == tboc_pkg::BOOT_SETTLE);
   wire panel_load = panel_s & ~panel_q;
   wire load_pulse = boot_load | panel_load;

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         settle <= 2'h0;
      end else if (i_clk_en && settle != 2'h3) begin
         settle <= settle + 2'h1;
      end
   end

   // ---------------------------------------------------------------
   // switch field decode, open switch reads as enabled
   // ---------------------------------------------------------------
   tboc_pkg::tboc_cfg_s next_cfg;
   always_comb begin
      next_cfg.rate_code = {bank_a_s[tboc_pkg::SWA_RATE_2], bank_a_s[tboc_pkg::SWA_RATE_1],
         bank_a_s[tboc_pkg::SWA_RATE_0]};
      next_cfg.ramp_code = {bank_a_s[tboc_pkg::SWA_RAMP_DELAY_HI], bank_a_s[tboc_pkg::SWA_RAMP_DELAY_LO]};
      next_cfg.block_code = {bank_a_s[tboc_pkg::SWA_BLOCK_LIMIT_HI], bank_a_s[tboc_pkg::SWA_BLOCK_LIMIT_LO]};
      next_cfg.single_track_write_fix = bank_a_s[tboc_pkg::SWA_SINGLE_TRACK_WRITE_FIX];
      next_cfg.cache_addr = {bank_a_s[tboc_pkg::SWA_CACHE_HI], bank_a_s[tboc_pkg::SWA_CACHE_LO]};
      next_cfg.write_retry = {bank_b_s[tboc_pkg::SWB_WRITE_RETRY_HI], bank_b_s[tboc_pkg::SWB_WRITE_RETRY_LO]};
      next_cfg.read_retry = {bank_b_s[tboc_pkg::SWB_READ_RETRY_HI], bank_b_s[tboc_pkg::SWB_READ_RETRY_LO]};
      next_cfg.tm_sync = bank_b_s[tboc_pkg::SWB_TM_SYNC];
      next_cfg.early_eot_single = bank_b_s[tboc_pkg::SWB_EARLY_EOT];
      next_cfg.long_record = bank_b_s[tboc_pkg::SWB_LONG_RECORD];
      next_cfg.fmt_addr = bank_b_s[tboc_pkg::SWB_FMT_ADDR];
      // bank b switch 7 and switch 10 have no field
   end

   // fields held static between loads
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_cfg <= '0;
         o_rate_kbps <= '0;
         o_rate_valid <= 1'b0;
         o_block_limit <= '0;
         o_cache_addr <= 2'h0;
         o_fmt_addr <= 1'b0;
      end else if (i_clk_en && load_pulse) begin
         o_cfg <= next_cfg;
         o_rate_kbps <= alt_s ? '0 : tboc_pkg::rate_of(next_cfg.rate_code);
         o_rate_valid <= ~alt_s;
         o_block_limit <= tboc_pkg::block_bytes(next_cfg.block_code);
         o_cache_addr <= next_cfg.cache_addr;
         o_fmt_addr <= next_cfg.fmt_addr;
      end
   end

   // ---------------------------------------------------------------
   // record mode
   // ---------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_long_record <= 1'b0;
      end else if (i_clk_en) begin
         if (load_pulse) o_long_record <= next_cfg.long_record;
         else if (i_mode_wr) o_long_record <= i_mode_long;
      end
   end

   // ---------------------------------------------------------------
   // interface ramp and host strobes
   // ---------------------------------------------------------------
   logic ramp_ok;
   wire [tboc_pkg::RAMP_CNT_W-1:0] ramp_cycles =
      tboc_pkg::RAMP_CNT_W'(tboc_pkg::ramp_min_ms(o_cfg.ramp_code) * P_MS_CYCLES);

   tboc_ramp_timer #(
      .P_CNT_W(tboc_pkg::RAMP_CNT_W)
   ) u_ramp (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_clk_en(i_clk_en),
      .i_busy(i_busy),
      .i_delay(ramp_cycles),
      .o_ramp_ok(ramp_ok)
   );

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_host_read_strobe <= 1'b0;
         o_host_write_strobe <= 1'b0;
      end else if (i_clk_en) begin
         o_host_read_strobe <= i_read_req & ramp_ok;
         o_host_write_strobe <= i_write_req & ramp_ok;
      end
   end

   // ---------------------------------------------------------------
   // buffer space and end of tape policy
   // ---------------------------------------------------------------
   wire space_short = i_free_space < P_FREE_W'(o_block_limit);
   wire single_mode = i_actual_eot | (i_early_eot & o_cfg.early_eot_single);
   wire four_mode = i_early_eot & ~single_mode;
   wire [tboc_pkg::REC_W-1:0] rec_limit = single_mode ? tboc_pkg::SINGLE_REC_LIMIT : tboc_pkg::EOT_REC_LIMIT;
   wire eot_limited = single_mode | four_mode;

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_read_ahead <= 1'b0;
         o_status_hold <= 1'b0;
         o_accept_write <= 1'b0;
         o_drain <= 1'b0;
         o_dummy_status_ok <= 1'b0;
         o_verify_first <= 1'b0;
      end else if (i_clk_en) begin
         o_read_ahead <= ~space_short;
         o_status_hold <= space_short;
         o_accept_write <= ~eot_limited | (i_rec_count < rec_limit);
         o_drain <= four_mode & (i_rec_count > tboc_pkg::EOT_REC_LIMIT);
         o_dummy_status_ok <= ~single_mode;
         o_verify_first <= single_mode;
      end
   end

   // ---------------------------------------------------------------
   // tape mark buffer sync
   // ---------------------------------------------------------------
   logic [1:0] tm_count;
   wire [1:0] tm_need = o_cfg.tm_sync ? tboc_pkg::TM_PAIR : tboc_pkg::TM_ONE;
   wire [1:0] tm_next = tm_count + 2'h1;
   wire tm_hit = i_tape_mark & (tm_next >= tm_need);

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tm_count <= 2'h0;
         o_buffer_sync <= 1'b0;
      end else if (i_clk_en) begin
         o_buffer_sync <= tm_hit;
         if (tm_hit || i_data_record) tm_count <= 2'h0;
         else if (i_tape_mark) tm_count <= tm_next;
      end
   end

   // ---------------------------------------------------------------
   // retry counters
   // ---------------------------------------------------------------
   logic [3:0] wr_count;
   logic [3:0] rd_count;
   wire [3:0] wr_limit = tboc_pkg::retry_limit(o_cfg.write_retry);
   wire [3:0] rd_limit = tboc_pkg::retry_limit(o_cfg.read_retry);
   wire track_block = i_one_track & ~o_cfg.single_track_write_fix;
   wire wr_go = i_wr_error & ~track_block & (wr_count < wr_limit);
   wire rd_go = i_rd_error & (rd_count < rd_limit);

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_count <= 4'h0;
         rd_count <= 4'h0;
         o_wr_retry <= 1'b0;
         o_wr_give_up <= 1'b0;
         o_rd_retry <= 1'b0;
         o_rd_give_up <= 1'b0;
      end else if (i_clk_en) begin
         o_wr_retry <= wr_go;
         o_wr_give_up <= i_wr_error & ~wr_go;
         o_rd_retry <= rd_go;
         o_rd_give_up <= i_rd_error & ~rd_go;
         if (i_wr_done) wr_count <= 4'h0;
         else if (wr_go) wr_count <= wr_count + 4'h1;
         if (i_rd_done) rd_count <= 4'h0;
         else if (rd_go) rd_count <= rd_count + 4'h1;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_rate_lookup: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      o_rate_valid |-> o_rate_kbps == tboc_pkg::rate_of(o_cfg.rate_code))
      else $error("rate does not match code");

   a_rate_alt_off: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      i_clk_en && load_pulse && alt_s |=> !o_rate_valid && o_rate_kbps == '0)
      else $error("rate bits used on alternate interface");

   a_block_limit: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      i_clk_en && load_pulse |=> o_block_limit == 16'(16'h2000 * (16'(o_cfg.block_code) + 16'h1)))
      else $error("block limit decode wrong");

   a_space_hold: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      i_clk_en && i_free_space < P_FREE_W'(o_block_limit) |=> !o_read_ahead && o_status_hold)
      else $error("read ahead with short buffer space");

   a_one_track_skip: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      i_clk_en && i_wr_error && i_one_track && !o_cfg.single_track_write_fix |=> !o_wr_retry && o_wr_give_up)
      else $error("single track error retried with fix off");

   a_read_retry_cap: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      i_clk_en && i_rd_error && rd_count >= tboc_pkg::retry_limit(o_cfg.read_retry) |=> !o_rd_retry)
      else $error("read retried past limit");

   a_write_retry_cap: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      i_clk_en && i_wr_error && wr_count >= tboc_pkg::retry_limit(o_cfg.write_retry) |=> !o_wr_retry)
      else $error("write retried past limit");

   a_single_tm_sync: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      i_clk_en && i_tape_mark && !o_cfg.tm_sync |=> o_buffer_sync)
      else $error("single tape mark did not sync");

   a_eot_one_record: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      i_clk_en && i_actual_eot && i_rec_count != '0 |=> !o_accept_write && !o_dummy_status_ok)
      else $error("second record taken at end of tape");

   a_drain_to_four: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      i_clk_en && i_early_eot && !i_actual_eot && !o_cfg.early_eot_single && i_rec_count > 4'h4
      |=> o_drain)
      else $error("no drain above four records");

   a_mode_default: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      i_clk_en && load_pulse |=> o_long_record == o_cfg.long_record)
      else $error("record mode not loaded from switch");

endmodule

// ===== test/tboc_host_model.sv
// tboc_host_model: host that drops busy and holds a read request until strobed
`timescale 1ns/10ps
module tboc_host_model (
   // clock and trigger
   input wire logic i_clock,
   input wire logic i_go,
   // strobe from the card
   input wire logic i_strobe,
   // host lines and measured wait
   output logic o_busy,
   output logic o_req,
   output int o_wait
);
   initial begin
      o_busy = 1'b1;
      o_req = 1'b0;
      o_wait = 0;
   end
   // request stays up until the card answers with a strobe
   always @(posedge i_clock) begin
      if (i_go && o_busy) begin
         o_busy <= 1'b0;
         o_req <= 1'b1;
         o_wait <= 0;
      end else if (!o_busy) begin
         o_wait <= o_wait + 1;
         if (i_strobe) begin
            o_req <= 1'b0;
            o_busy <= 1'b1;
         end
      end
   end
endmodule

// ===== test/test_tboc_top.sv
// test_tboc_top: self-checking bench of the option loader and buffer policy
`timescale 1ns/10ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
   $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module test_tboc_top;
   logic i_clock, i_rst_n, i_panel_reset, i_alt_interface, i_early_eot, i_actual_eot, go;
   logic i_tape_mark, i_data_record, i_wr_error, i_one_track, i_wr_done, i_rd_error, i_rd_done;
   logic [9:0] i_bank_a, i_bank_b, rate;
   logic [16:0] i_free_space;
   logic [3:0] i_rec_count;
   logic [15:0] blk;
   logic [1:0] cache;
   logic busy, req, rv, fmt, lng, rds, wrs, ra, sh, aw, dr, dso, vf, bs, wrr, wrg, rdr, rdg;
   tboc_pkg::tboc_cfg_s cfg;
   int wait_c, fails = 0, tests_run = 0, nsync, nwr, nwg, nrr, nrg, nws;
   logic [9:0] rt[8] = '{10'h3e8, 10'h341, 10'h2ca, 10'h271, 10'h1f4, 10'h139, 10'h0c8, 10'h04c};
   logic [3:0] rl[4] = '{4'h0, 4'h5, 4'ha, 4'hf};
   logic [7:0] ms[4] = '{8'h04, 8'h10, 8'h20, 8'h30};
   tboc_top #(.P_MS_CYCLES(4)) tboc_top_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_clk_en(1'b1),
      .i_bank_a(i_bank_a), .i_bank_b(i_bank_b), .i_alt_interface(i_alt_interface),
      .i_panel_reset(i_panel_reset), .i_busy(busy), .i_read_req(req), .i_write_req(req),
      .i_free_space(i_free_space), .i_rec_count(i_rec_count), .i_early_eot(i_early_eot),
      .i_actual_eot(i_actual_eot), .i_tape_mark(i_tape_mark), .i_data_record(i_data_record),
      .i_wr_error(i_wr_error), .i_one_track(i_one_track), .i_wr_done(i_wr_done),
      .i_rd_error(i_rd_error), .i_rd_done(i_rd_done), .i_mode_wr(1'b0), .i_mode_long(1'b0),
      .o_cfg(cfg), .o_rate_kbps(rate), .o_rate_valid(rv), .o_block_limit(blk), .o_cache_addr(cache),
      .o_fmt_addr(fmt), .o_long_record(lng), .o_host_read_strobe(rds), .o_host_write_strobe(wrs),
      .o_read_ahead(ra), .o_status_hold(sh), .o_accept_write(aw), .o_drain(dr),
      .o_dummy_status_ok(dso), .o_verify_first(vf), .o_buffer_sync(bs), .o_wr_retry(wrr),
      .o_wr_give_up(wrg), .o_rd_retry(rdr), .o_rd_give_up(rdg));
   tboc_host_model tboc_host_model_i (.i_clock(i_clock), .i_go(go), .i_strobe(rds), .o_busy(busy),
      .o_req(req), .o_wait(wait_c));
   // -------------------------------------------
   // clock, pulse counters and helpers
   // -------------------------------------------
   initial begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end
   always @(posedge i_clock) begin
      nsync += (bs === 1'b1);
      nwr += (wrr === 1'b1);
      nwg += (wrg === 1'b1);
      nrr += (rdr === 1'b1);
      nrg += (rdg === 1'b1);
      nws += (wrs === 1'b1);
   end
   task cyc(input int n);
      repeat (n) @(posedge i_clock);
   endtask
   task load(input logic [9:0] a, input logic [9:0] b);
      @(posedge i_clock);
      i_bank_a <= a;
      i_bank_b <= b;
      i_panel_reset <= 1'b1;
      cyc(1);
      i_panel_reset <= 1'b0;
      cyc(8);
      @(posedge i_clock) {i_wr_done, i_rd_done} <= 2'h3;
      @(posedge i_clock) {i_wr_done, i_rd_done} <= 2'h0;
      cyc(1);
      #1;
      {nsync, nwr, nwg, nrr, nrg, nws} = '0;
   endtask
   task buf_set(input logic [3:0] r, input logic ee, input logic ae);
      @(posedge i_clock);
      i_rec_count <= r;
      i_early_eot <= ee;
      i_actual_eot <= ae;
      cyc(2);
      #1;
   endtask
   task err(input int n, input logic ot);
      repeat (n) begin
         @(posedge i_clock) {i_wr_error, i_rd_error, i_one_track} <= {2'h3, ot};
         @(posedge i_clock) {i_wr_error, i_rd_error} <= 2'h0;
      end
      cyc(2);
      #1;
   endtask
   task tmk;
      @(posedge i_clock) i_tape_mark <= 1'b1;
      @(posedge i_clock) i_tape_mark <= 1'b0;
   endtask
   // -------------------------------------------
   // scenarios
   // -------------------------------------------
   task t_cfg;
      for (int c = 0; c < 8; c++) begin
         load({c[1:0], 1'b0, c[2], c[1:0], 2'h0, c[1:0]}, {1'b0, c[0], c[1], c[0], 6'h00});
         `CHK(rate, rt[c])
         `CHK(blk, 16'(16'h2000 * (c % 4 + 1)))
         `CHK(cache, c[1:0])
         `CHK({fmt, lng, rv}, {c[0], c[1], 1'b1})
         `CHK(cfg, {c[2:0], 2'h0, c[1:0], 1'b0, c[1:0], 4'h0, 2'h0, c[1], c[0]})
      end
      @(posedge i_clock) i_alt_interface <= 1'b1;
      load(10'h3ff, 10'h000);
      `CHK({rate, rv}, 11'h000)
      @(posedge i_clock) i_bank_a <= 10'h000;
      i_alt_interface <= 1'b0;
      cyc(8);
      #1;
      `CHK({cache, blk}, 18'h38000)
      $display("test cfg done");
   endtask
   task t_ramp;
      int k;
      for (int c = 0; c < 4; c++) begin
         load({6'h00, c[1:0], 2'h0}, 10'h000);
         @(posedge i_clock) go <= 1'b1;
         @(posedge i_clock) go <= 1'b0;
         #1;
         k = 0;
         while (busy !== 1'b1 && k < 300) begin
            @(posedge i_clock);
            k++;
         end
         #1;
         `CHK(wait_c >= ms[c] && wait_c <= ms[c] + 4, 1'b1)
         `CHK(wrs, 1'b0)
         `CHK(nws, 2)
      end
      $display("test ramp done");
   endtask
   task t_buf;
      load(10'h010, 10'h020);
      @(posedge i_clock) i_free_space <= 17'h03fff;
      buf_set(4'h1, 1'b1, 1'b0);
      `CHK({ra, sh}, 2'h1)
      `CHK({aw, dso, vf}, 3'h1)
      @(posedge i_clock) i_free_space <= 17'h04000;
      buf_set(4'h0, 1'b1, 1'b0);
      `CHK({ra, sh, aw}, 3'h5)
      load(10'h000, 10'h000);
      buf_set(4'h3, 1'b1, 1'b0);
      `CHK({aw, dr}, 2'h2)
      buf_set(4'h4, 1'b1, 1'b0);
      `CHK({aw, dr}, 2'h0)
      buf_set(4'h5, 1'b1, 1'b0);
      `CHK(dr, 1'b1)
      buf_set(4'h1, 1'b0, 1'b1);
      `CHK({aw, dso, vf}, 3'h1)
      buf_set(4'h0, 1'b0, 1'b0);
      $display("test buffer done");
   endtask
   task t_tm;
      load(10'h000, 10'h010);
      tmk();
      @(posedge i_clock) i_data_record <= 1'b1;
      @(posedge i_clock) i_data_record <= 1'b0;
      tmk();
      cyc(3);
      `CHK(nsync, 0)
      tmk();
      cyc(3);
      `CHK(nsync, 1)
      load(10'h000, 10'h000);
      tmk();
      cyc(3);
      `CHK(nsync, 1)
      $display("test tape mark done");
   endtask
   task t_retry;
      for (int c = 0; c < 4; c++) begin
         load(10'h000, {6'h00, 2'(3 - c), c[1:0]});
         err(16, 1'b0);
         `CHK({nwr, nwg}, {int'(rl[c]), 16 - rl[c]})
         `CHK({nrr, nrg}, {int'(rl[3 - c]), 16 - rl[3 - c]})
      end
      load(10'h000, 10'h003);
      err(1, 1'b1);
      `CHK({nwr, nwg}, {32'h0, 32'h1})
      load(10'h080, 10'h003);
      err(1, 1'b1);
      `CHK({nwr, nwg}, {32'h1, 32'h0})
      $display("test retry done");
   endtask
   task summarize;
      $display("tests_run=%0d fails=%0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #100us;
      fails++;
      summarize();
   end
   initial begin
      {i_rst_n, i_panel_reset, i_alt_interface, i_early_eot, i_actual_eot, go} = '0;
      {i_tape_mark, i_data_record, i_wr_error, i_one_track, i_wr_done, i_rd_error, i_rd_done} = '0;
      i_bank_a = 10'h000;
      i_bank_b = 10'h080;
      i_free_space = 17'h1ffff;
      i_rec_count = 4'h0;
      cyc(2);
      i_rst_n <= 1'b1;
      cyc(6);
      #1;
      `CHK({lng, blk}, 17'h12000)
      t_cfg();
      t_ramp();
      t_buf();
      t_tm();
      t_retry();
      summarize();
   end
endmodule
